// >>> verilog/swm_pkg.sv
package swm_pkg;
  // ---------------------------------------------------------------
  // Clock in MHz, timing figures in microseconds
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 40;
  localparam int SAMPLE_STD_US    = 30;
  localparam int SAMPLE_OD_US     = 3;
  localparam int RST_DET_STD_US   = 120;
  localparam int RST_DET_OD_US    = 16;
  localparam int PRES_WAIT_STD_US = 30;
  localparam int PRES_WAIT_OD_US  = 3;
  localparam int PRES_LOW_STD_US  = 60;
  localparam int PRES_LOW_OD_US   = 10;
  localparam int RD_HOLD_STD_US   = 30;
  localparam int RD_HOLD_OD_US    = 3;
  localparam int COPY_DURATION_US = 10000;
  localparam int RST_LOW_STD_US   = 480;
  localparam int RST_LOW_OD_US    = 48;
  localparam int PRES_SMP_STD_US  = 70;
  localparam int PRES_SMP_OD_US   = 8;
  localparam int SLOT_STD_US      = 65;
  localparam int SLOT_OD_US       = 8;
  localparam int W1_LOW_STD_US    = 5;
  localparam int W1_LOW_OD_US     = 1;
  localparam int RD_LOW_US        = 1;
  localparam int RDV_STD_US       = 15;
  localparam int RDV_OD_US        = 2;
  localparam int REC_US           = 2;
  // ---------------------------------------------------------------
  // Same figures in clock cycles
  // ---------------------------------------------------------------
  localparam int SAMPLE_STD_CYC    = SAMPLE_STD_US * CLK_MHZ;
  localparam int SAMPLE_OD_CYC     = SAMPLE_OD_US * CLK_MHZ;
  localparam int RST_DET_STD_CYC   = RST_DET_STD_US * CLK_MHZ;
  localparam int RST_DET_OD_CYC    = RST_DET_OD_US * CLK_MHZ;
  localparam int PRES_WAIT_STD_CYC = PRES_WAIT_STD_US * CLK_MHZ;
  localparam int PRES_WAIT_OD_CYC  = PRES_WAIT_OD_US * CLK_MHZ;
  localparam int PRES_LOW_STD_CYC  = PRES_LOW_STD_US * CLK_MHZ;
  localparam int PRES_LOW_OD_CYC   = PRES_LOW_OD_US * CLK_MHZ;
  localparam int RD_HOLD_STD_CYC   = RD_HOLD_STD_US * CLK_MHZ;
  localparam int RD_HOLD_OD_CYC    = RD_HOLD_OD_US * CLK_MHZ;
  localparam int COPY_CYC          = COPY_DURATION_US * CLK_MHZ;
  localparam int RST_LOW_STD_CYC   = RST_LOW_STD_US * CLK_MHZ;
  localparam int RST_LOW_OD_CYC    = RST_LOW_OD_US * CLK_MHZ;
  localparam int PRES_SMP_STD_CYC  = PRES_SMP_STD_US * CLK_MHZ;
  localparam int PRES_SMP_OD_CYC   = PRES_SMP_OD_US * CLK_MHZ;
  localparam int SLOT_STD_CYC      = SLOT_STD_US * CLK_MHZ;
  localparam int SLOT_OD_CYC       = SLOT_OD_US * CLK_MHZ;
  localparam int W1_LOW_STD_CYC    = W1_LOW_STD_US * CLK_MHZ;
  localparam int W1_LOW_OD_CYC     = W1_LOW_OD_US * CLK_MHZ;
  localparam int RD_LOW_CYC        = RD_LOW_US * CLK_MHZ;
  localparam int RDV_STD_CYC       = RDV_STD_US * CLK_MHZ;
  localparam int RDV_OD_CYC        = RDV_OD_US * CLK_MHZ;
  localparam int REC_CYC           = REC_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // Commands and memory map
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_SKIP     = 8'hCC;
  localparam logic [7:0] OP_READ     = 8'h69;
  localparam logic [7:0] OP_WRITE    = 8'h6C;
  localparam logic [7:0] OP_COPY     = 8'h48;
  localparam logic [7:0] OP_RECALL   = 8'hB8;
  localparam logic [7:0] OP_LOCK     = 8'h6A;
  localparam logic [7:0] CTRL_ADDR   = 8'h1F;
  localparam int         CTRL_ARM    = 6;
  localparam int         CTRL_BUSY   = 7;
  localparam logic [7:0] RO_TOP      = 8'h0F;
  localparam logic [7:0] RSVD_BASE   = 8'h80;
  localparam logic [2:0] NV_TAG      = 3'h1;
  localparam int         NV_BLK_BIT  = 4;
  localparam int         NV_BLK_SIZE = 16;
  // Host register offsets and commands
  localparam logic [3:0] H_CMD       = 4'h0;
  localparam logic [3:0] H_DATA      = 4'h4;
  localparam logic [3:0] H_STAT      = 4'h8;
  localparam logic [3:0] H_CTRL      = 4'hC;
  localparam logic [1:0] HOP_RESET   = 2'h0;
  localparam logic [1:0] HOP_WRITE   = 2'h1;
  localparam logic [1:0] HOP_READ    = 2'h2;

  function automatic int sel(input logic od, input int s, input int o);
    return od ? o : s;
  endfunction : sel

  function automatic logic is_nv(input logic [7:0] a);
    return a[7:5] == NV_TAG;
  endfunction : is_nv
endpackage : swm_pkg

// >>> verilog/swm_if.sv
`timescale 1ns/100ps
interface swm_if;
  logic dq;
  logic speed_select_pin;
  logic host_dq_o;
  logic host_dq_oe;
  logic dev_dq_o;
  logic dev_dq_oe;

  // Open drain with pull-up: low if any end drives a zero
  assign dq = !((host_dq_oe && !host_dq_o) || (dev_dq_oe && !dev_dq_o));

  modport device (input dq, input speed_select_pin,
                  output dev_dq_o, output dev_dq_oe);
  modport host   (input dq, output speed_select_pin,
                  output host_dq_o, output host_dq_oe);
endinterface : swm_if

// >>> verilog/swm_device.sv
`timescale 1ns/100ps
// Summary of operation
// [RULE1] Write command stores bytes, address advances
// [RULE2] Write address wraps from top to zero
// [RULE3] Drop protected, read-only, reserved, partial writes
// [RULE4] Block writes touch shadow copy only
// [RULE5] Copy programs whole block unless locked
// [RULE6] Copy flag set, block writes ignored
// [RULE7] Copy starts next falling edge, fixed duration
// [RULE8] Recall loads shadow block from cells
// [RULE9] Lock works only right after arming
// [RULE10] Locked block refuses writes and copies forever
// [RULE11] Master sends no data after copy
// [RULE12] Reset low, wait, then presence pulse
// [RULE13] Master starts all but presence pulse
// [RULE14] Master slots start falling, recovery between
// [RULE15] Sample write slot inside speed window
// [RULE16] Master releases early for one
// [RULE17] Master holds read low briefly, samples
// [RULE18] Drive read bit, release before slot end
// [RULE19] Read returns bytes, address wraps
// [RULE20] Speed pin picks standard or overdrive
// [RULE21] Long low abandons the transaction
// [RULE22] Bus reset aborts all but running copy
// [RULE23] Timing counted on the local clock
module swm_device #(
  parameter int RST_DET_CYC = swm_pkg::RST_DET_STD_CYC,
  parameter int COPY_CYCLES = swm_pkg::COPY_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  swm_if.device     bus,
  output logic      o_copy_in_progress,
  output logic      o_overdrive
);
  import swm_pkg::*;

  localparam int CW = $clog2(COPY_CYCLES + 1);

  if (COPY_CYCLES < NV_BLK_SIZE || RST_DET_CYC > 65535 ||
      RST_DET_CYC <= SLOT_STD_CYC) begin : g_chk
    $error("swm_device: unusable timing parameters");
  end

  typedef enum logic [3:0] {
    P_IDLE, P_RST, P_PWAIT, P_PLOW, P_NET, P_FUNC,
    P_ADDR, P_WRITE, P_READ, P_ARMCOPY, P_HALT
  } pst_t;

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          prev;
    logic          spd1;
    logic          spd2;
    logic          od;
    logic [15:0]   tmr;
    logic          slot;
    logic [2:0]    bitn;
    logic [7:0]    sh;
    logic [7:0]    addr;
    logic [7:0]    cmd;
    pst_t          pst;
    logic          drv;
    logic          arm;
    logic [1:0]    lock;
    logic          cpy;
    logic          cpy_blk;
    logic [CW-1:0] ccnt;
    logic          rcl;
    logic          rcl_blk;
    logic [3:0]    rcnt;
  } dev_t;

  dev_t r_reg;
  dev_t r_next;

  logic [7:0] shadow [256];
  logic [7:0] nv_cell [2*NV_BLK_SIZE];

  logic       sh_we;
  logic [7:0] sh_wa;
  logic [7:0] sh_wd;
  logic       nv_we;
  logic [4:0] nv_wa;

  logic       fall;
  logic       rise;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_byte;
  logic [7:0] nbyte;

  function automatic logic wr_ok(input logic [7:0] a, input logic cpy,
                                 input logic [1:0] lk);
    if (a <= RO_TOP || a >= RSVD_BASE || a == CTRL_ADDR)
      return 1'b0;
    if (is_nv(a))
      return !cpy && !lk[a[NV_BLK_BIT]];
    return 1'b1;
  endfunction : wr_ok

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    r_next    = r_reg;
    sh_we     = 1'b0;
    sh_wa     = r_reg.addr;
    sh_wd     = r_reg.sh;
    nv_we     = 1'b0;
    nv_wa     = {r_reg.cpy_blk, r_reg.ccnt[3:0]};
    fall      = r_reg.prev && !r_reg.s2;
    rise      = !r_reg.prev && r_reg.s2;
    ctrl_byte = {r_reg.cpy, r_reg.arm, 4'h0, r_reg.lock};
    rd_byte   = (r_reg.addr == CTRL_ADDR) ? ctrl_byte : shadow[r_reg.addr];
    nbyte     = {r_reg.s2, r_reg.sh[7:1]};

    r_next.s1   = bus.dq;
    r_next.s2   = r_reg.s1;
    r_next.prev = r_reg.s2;
    r_next.spd1 = bus.speed_select_pin;
    r_next.spd2 = r_reg.spd1;
    if (r_reg.tmr != 16'hFFFF)
      r_next.tmr = r_reg.tmr + 16'h0001;                           // [RULE23]

    // Copy keeps running through bus resets
    if (r_reg.cpy) begin
      nv_we       = r_reg.ccnt < CW'(NV_BLK_SIZE);                 // [RULE5]
      r_next.ccnt = r_reg.ccnt + 1'b1;
      if (r_reg.ccnt == CW'(COPY_CYCLES - 1))
        r_next.cpy = 1'b0;                                         // [RULE7]
    end
    if (r_reg.rcl) begin
      sh_we       = 1'b1;                                          // [RULE8]
      sh_wa       = {NV_TAG, r_reg.rcl_blk, r_reg.rcnt};
      sh_wd       = nv_cell[{r_reg.rcl_blk, r_reg.rcnt}];
      r_next.rcnt = r_reg.rcnt + 4'h1;
      if (r_reg.rcnt == 4'hF)
        r_next.rcl = 1'b0;
    end

    case (r_reg.pst)
      P_PWAIT: begin
        if (r_reg.tmr == 16'(sel(r_reg.od, PRES_WAIT_STD_CYC,
                                 PRES_WAIT_OD_CYC) - 1)) begin
          r_next.drv = 1'b1;                                       // [RULE12]
          r_next.tmr = 16'h0000;
          r_next.pst = P_PLOW;
        end
      end
      P_PLOW: begin
        if (r_reg.tmr == 16'(sel(r_reg.od, PRES_LOW_STD_CYC,
                                 PRES_LOW_OD_CYC) - 1)) begin
          r_next.drv  = 1'b0;                                      // [RULE13]
          r_next.pst  = P_NET;
          r_next.bitn = 3'h0;
        end
      end
      default: begin
        if (fall) begin
          r_next.tmr  = 16'h0000;
          r_next.slot = 1'b1;
          // Pull low at once for a zero; the master is low anyway
          if (r_reg.pst == P_READ && !rd_byte[r_reg.bitn])
            r_next.drv = 1'b1;                                     // [RULE18]
          if (r_reg.pst == P_ARMCOPY) begin
            r_next.pst = P_HALT;
            if (is_nv(r_reg.addr) && !r_reg.cpy &&
                !r_reg.lock[r_reg.addr[NV_BLK_BIT]]) begin         // [RULE10]
              r_next.cpy     = 1'b1;                               // [RULE7]
              r_next.ccnt    = '0;
              r_next.cpy_blk = r_reg.addr[NV_BLK_BIT];
            end
          end
        end
        if (r_reg.drv && r_reg.tmr == 16'(sel(r_reg.od, RD_HOLD_STD_CYC,
                                              RD_HOLD_OD_CYC) - 1))
          r_next.drv = 1'b0;                                       // [RULE18]
        if (r_reg.slot && !fall && r_reg.tmr == 16'(sel(r_reg.od,
            SAMPLE_STD_CYC, SAMPLE_OD_CYC) - 1)) begin
          r_next.slot = 1'b0;
          r_next.sh   = nbyte;                                     // [RULE15]
          r_next.bitn = r_reg.bitn + 3'h1;
          if (r_reg.bitn == 3'h7) begin
            case (r_reg.pst)
              P_NET:
                r_next.pst = (nbyte == OP_SKIP) ? P_FUNC : P_HALT;
              P_FUNC: begin
                r_next.cmd = nbyte;
                r_next.pst = P_HALT;
                if (nbyte != OP_LOCK)
                  r_next.arm = 1'b0;                               // [RULE9]
                if (nbyte == OP_READ || nbyte == OP_WRITE ||
                    nbyte == OP_COPY || nbyte == OP_RECALL ||
                    nbyte == OP_LOCK)
                  r_next.pst = P_ADDR;
              end
              P_ADDR: begin
                r_next.addr = nbyte;
                r_next.pst  = P_HALT;
                case (r_reg.cmd)
                  OP_READ:  r_next.pst = P_READ;                   // [RULE19]
                  OP_WRITE: r_next.pst = P_WRITE;                  // [RULE1]
                  OP_COPY:  r_next.pst = P_ARMCOPY;                // [RULE7]
                  OP_RECALL: begin
                    if (is_nv(nbyte) && !r_reg.cpy) begin
                      r_next.rcl     = 1'b1;                       // [RULE8]
                      r_next.rcnt    = 4'h0;
                      r_next.rcl_blk = nbyte[NV_BLK_BIT];
                    end
                  end
                  OP_LOCK: begin
                    r_next.arm = 1'b0;
                    if (r_reg.arm && is_nv(nbyte))
                      r_next.lock[nbyte[NV_BLK_BIT]] = 1'b1;       // [RULE9]
                  end
                  default: r_next.pst = P_HALT;
                endcase
              end
              P_WRITE: begin
                // Only a full eighth bit reaches here
                r_next.addr = r_reg.addr + 8'h01;                  // [RULE2]
                r_next.arm  = (r_reg.addr == CTRL_ADDR) && nbyte[CTRL_ARM];
                if (wr_ok(r_reg.addr, r_reg.cpy, r_reg.lock)) begin
                  sh_we = 1'b1;                                    // [RULE3]
                  sh_wa = r_reg.addr;                              // [RULE4]
                  sh_wd = nbyte;                                   // [RULE6]
                end
              end
              P_READ: begin
                r_next.addr = r_reg.addr + 8'h01;                  // [RULE19]
                r_next.arm  = 1'b0;
              end
              default: r_next.pst = r_reg.pst;
            endcase
          end
        end
        if (r_reg.pst == P_RST && rise) begin
          r_next.tmr = 16'h0000;                                   // [RULE12]
          r_next.pst = P_PWAIT;
        end
      end
    endcase

    // Long low: reset pulse, checked in every bus state but presence
    // Pin speed, not the latched one, so a speed change is caught
    if (r_reg.pst != P_PWAIT && r_reg.pst != P_PLOW && !r_reg.s2 &&
        r_reg.tmr == 16'(sel(r_reg.spd2, RST_DET_CYC, RST_DET_OD_CYC))) begin
      r_next.pst  = P_RST;                                         // [RULE21]
      r_next.drv  = 1'b0;                                          // [RULE22]
      r_next.slot = 1'b0;
      r_next.od   = r_reg.spd2;                                    // [RULE20]
    end
    // Speed keeps following the pin for as long as the reset low lasts
    if (r_reg.pst == P_RST && !r_reg.s2)
      r_next.od = r_reg.spd2;                                      // [RULE20]
  end

  // ---------------------------------------------------------------
  // Registers and memories
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r_reg      <= '0;
      r_reg.s1   <= 1'b1;
      r_reg.s2   <= 1'b1;
      r_reg.prev <= 1'b1;
      r_reg.tmr  <= 16'hFFFF;
      r_reg.pst  <= P_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (sh_we)
      shadow[sh_wa] <= sh_wd;
    if (nv_we)
      nv_cell[nv_wa] <= shadow[{NV_TAG, nv_wa}];                   // [RULE4]
  end

  assign bus.dev_dq_o       = 1'b0;
  assign bus.dev_dq_oe      = r_reg.drv;
  assign o_copy_in_progress = r_reg.cpy;                           // [RULE6]
  assign o_overdrive        = r_reg.od;
endmodule : swm_device

// >>> verilog/swm_host.sv
`timescale 1ns/100ps
module swm_host #(
  parameter int RST_LOW_CYC = swm_pkg::RST_LOW_STD_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  swm_if.host             bus,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  output logic            o_busy
);
  import swm_pkg::*;

  if (RST_LOW_CYC > 65535 ||
      RST_LOW_CYC <= PRES_WAIT_STD_CYC + PRES_LOW_STD_CYC) begin : g_chk
    $error("swm_host: unusable reset length");
  end

  typedef enum logic [2:0] {H_IDLE, H_RLOW, H_RHIGH, H_SLOT, H_REC} hst_t;

  typedef struct packed {
    logic        s1;
    logic        s2;
    hst_t        hs;
    logic [15:0] tmr;
    logic [2:0]  bitn;
    logic [7:0]  sh;
    logic [1:0]  op;
    logic        pres;
    logic        busy;
    logic        od;
    logic        drv;
    logic [7:0]  rdata;
  } host_t;

  host_t r_reg;
  host_t r_next;
  logic  one;

  always_comb begin
    r_next       = r_reg;
    r_next.s1    = bus.dq;
    r_next.s2    = r_reg.s1;
    r_next.tmr   = r_reg.tmr + 16'h0001;
    r_next.rdata = 8'h00;
    one          = (r_reg.op == HOP_READ) || r_reg.sh[0];

    if (i_rd) begin
      case (i_addr)
        H_DATA:  r_next.rdata = r_reg.sh;
        H_STAT:  r_next.rdata = {6'h00, r_reg.pres, r_reg.busy};
        H_CTRL:  r_next.rdata = {7'h00, r_reg.od};
        default: r_next.rdata = 8'h00;
      endcase
    end
    // Writes while busy are dropped
    if (i_wr && !r_reg.busy) begin
      case (i_addr)
        H_DATA: r_next.sh = i_wdata;
        H_CTRL: r_next.od = i_wdata[0];
        H_CMD: begin
          r_next.op   = i_wdata[1:0];
          r_next.busy = 1'b1;
          r_next.drv  = 1'b1;                                      // [RULE13]
          r_next.tmr  = 16'h0000;
          r_next.bitn = 3'h0;
          r_next.hs   = (i_wdata[1:0] == HOP_RESET) ? H_RLOW : H_SLOT;
        end
        default: r_next.busy = r_reg.busy;
      endcase
    end

    case (r_reg.hs)
      H_RLOW: begin
        if (r_reg.tmr == 16'(sel(r_reg.od, RST_LOW_CYC,
                                 RST_LOW_OD_CYC) - 1)) begin
          r_next.drv = 1'b0;                                       // [RULE12]
          r_next.tmr = 16'h0000;
          r_next.hs  = H_RHIGH;
        end
      end
      H_RHIGH: begin
        if (r_reg.tmr == 16'(sel(r_reg.od, PRES_SMP_STD_CYC,
                                 PRES_SMP_OD_CYC) - 1))
          r_next.pres = !r_reg.s2;                                 // [RULE12]
        if (r_reg.tmr == 16'(sel(r_reg.od, RST_LOW_CYC,
                                 RST_LOW_OD_CYC) - 1)) begin
          r_next.busy = 1'b0;
          r_next.hs   = H_IDLE;
        end
      end
      H_SLOT: begin
        if (one && r_reg.tmr == 16'((r_reg.op == HOP_READ) ? RD_LOW_CYC :
            sel(r_reg.od, W1_LOW_STD_CYC, W1_LOW_OD_CYC)) - 16'h0001)
          r_next.drv = 1'b0;                                       // [RULE16]
        if (r_reg.op == HOP_READ && r_reg.tmr == 16'(sel(r_reg.od,
            RDV_STD_CYC, RDV_OD_CYC) - 1))
          r_next.sh = {r_reg.s2, r_reg.sh[7:1]};                   // [RULE17]
        if (r_reg.tmr == 16'(sel(r_reg.od, SLOT_STD_CYC,
                                 SLOT_OD_CYC) - 1)) begin
          r_next.drv = 1'b0;                                       // [RULE14]
          r_next.tmr = 16'h0000;
          r_next.hs  = H_REC;
          if (r_reg.op != HOP_READ)
            r_next.sh = {r_reg.sh[0], r_reg.sh[7:1]};              // [RULE1]
        end
      end
      H_REC: begin
        if (r_reg.tmr == 16'(REC_CYC - 1)) begin
          r_next.tmr = 16'h0000;
          if (r_reg.bitn == 3'h7) begin
            r_next.busy = 1'b0;
            r_next.hs   = H_IDLE;
          end else begin
            r_next.bitn = r_reg.bitn + 3'h1;
            r_next.drv  = 1'b1;                                    // [RULE14]
            r_next.hs   = H_SLOT;
          end
        end
      end
      default: r_next.tmr = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r_reg    <= '0;
      r_reg.s1 <= 1'b1;
      r_reg.s2 <= 1'b1;
      r_reg.hs <= H_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.host_dq_o        = 1'b0;
  assign bus.host_dq_oe       = r_reg.drv;
  assign bus.speed_select_pin = r_reg.od;                          // [RULE20]
  assign o_rdata              = r_reg.rdata;
  assign o_busy               = r_reg.busy;
endmodule : swm_host

// >>> verification/swm_assertions.sv
`timescale 1ns/100ps
module swm_assertions
  import swm_pkg::*;
#(
  parameter int COPY_CYCLES = 64
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic dq,
  input wire logic speed_select_pin,
  input wire logic host_dq_o,
  input wire logic host_dq_oe,
  input wire logic dev_dq_o,
  input wire logic dev_dq_oe,
  input wire logic o_copy_in_progress,
  input wire logic o_overdrive
);
  // ---------------------------------------------------------------
  // Run lengths; the idle-high count saturates so it cannot wrap
  // ---------------------------------------------------------------
  logic [15:0] hi_reg;
  logic [15:0] lo_reg;
  logic [15:0] oe_reg;
  logic [15:0] cp_reg;
  logic        pres_reg;
  int          pw;
  int          pl;
  int          rh;
  assign pw = o_overdrive ? PRES_WAIT_OD_CYC : PRES_WAIT_STD_CYC;
  assign pl = o_overdrive ? PRES_LOW_OD_CYC : PRES_LOW_STD_CYC;
  assign rh = o_overdrive ? RD_HOLD_OD_CYC : RD_HOLD_STD_CYC;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hi_reg   <= 16'h0000;
      lo_reg   <= 16'h0000;
      oe_reg   <= 16'h0000;
      cp_reg   <= 16'h0000;
      pres_reg <= 1'h0;
    end else begin
      hi_reg   <= dq ? hi_reg + {15'h0000, ~&hi_reg} : 16'h0000;
      lo_reg   <= dq ? 16'h0000 : lo_reg + 16'h0001;
      oe_reg   <= dev_dq_oe ? oe_reg + 16'h0001 : 16'h0000;
      cp_reg   <= o_copy_in_progress ? cp_reg + 16'h0001 : 16'h0000;
      if (dev_dq_oe && oe_reg == 16'h0000) begin
        pres_reg <= !host_dq_oe;
      end
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_pres_start;
    $rose(dev_dq_oe) && !host_dq_oe;
  endsequence
  sequence s_read_drive;
    $rose(dev_dq_oe) && host_dq_oe;
  endsequence
  a_open_drain: assert property (
    (dev_dq_oe |-> !dev_dq_o) and (host_dq_oe |-> !host_dq_o))
    else $error("driven high level on line");
  a_pres_wait: assert property (
    s_pres_start |-> hi_reg inside {[pw:pw+5]})
    else $error("presence wait wrong");
  a_pres_len: assert property (
    $fell(dev_dq_oe) && pres_reg |-> oe_reg inside {[pl-1:pl+1]})
    else $error("presence length wrong");
  a_read_start: assert property (
    s_read_drive |-> lo_reg inside {[1:8]})
    else $error("device drive not tied to master fall");
  a_read_hold: assert property (
    $fell(dev_dq_oe) && !pres_reg |-> oe_reg inside {[rh-12:rh]})
    else $error("read bit hold wrong");
  a_reset_quiet: assert property (
    host_dq_oe && lo_reg > 16'h0514 |-> !dev_dq_oe)
    else $error("device drives during reset low");
  a_copy_start: assert property (
    $rose(o_copy_in_progress) |-> lo_reg inside {[1:8]})
    else $error("copy not started on falling edge");
  a_copy_len: assert property (
    $fell(o_copy_in_progress) |->
      cp_reg inside {[COPY_CYCLES-1:COPY_CYCLES+1]})
    else $error("copy duration wrong");
  a_speed_latch: assert property (
    $changed(o_overdrive) |-> !$past(dq)
      && o_overdrive == $past(speed_select_pin))
    else $error("speed changed outside reset low");
  a_host_recovery: assert property (
    $fell(host_dq_oe) |-> !host_dq_oe [*8])
    else $error("slot recovery too short");
endmodule : swm_assertions

// >>> verification/single_wire_memory_function_slave_tb.sv
`timescale 1ns/100ps
module single_wire_memory_function_slave_tb;
  import swm_pkg::*;
  localparam int COPY_N = 64;
  logic       i_clk;
  logic       i_sys_rst;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  logic       o_busy;
  logic       o_copy_in_progress;
  logic       o_overdrive;
  int         n_errors;
  int         compares;
  swm_if bus ();
  swm_device #(.RST_DET_CYC(4800), .COPY_CYCLES(COPY_N)) u_swm_device (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus),
    .o_copy_in_progress(o_copy_in_progress), .o_overdrive(o_overdrive));
  swm_host #(.RST_LOW_CYC(5000)) u_swm_host (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_busy(o_busy));
  swm_assertions #(.COPY_CYCLES(COPY_N)) u_swm_assertions (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .dq(bus.dq),
    .speed_select_pin(bus.speed_select_pin), .host_dq_o(bus.host_dq_o),
    .host_dq_oe(bus.host_dq_oe), .dev_dq_o(bus.dev_dq_o),
    .dev_dq_oe(bus.dev_dq_oe), .o_copy_in_progress(o_copy_in_progress),
    .o_overdrive(o_overdrive));
  // ---------------------------------------------------------------
  // Register port and byte tasks
  // ---------------------------------------------------------------
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'h1;
    @(posedge i_clk);
    i_wr    <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'h1;
    @(posedge i_clk);
    i_rd   <= 1'h0;
    #1;
    d = o_rdata;
  endtask : rd
  task automatic idle();
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 8000 && s[0] !== 1'h0; i++) rd(H_STAT, s);
    chk("busy", 8'h00, {7'h00, s[0]});
  endtask : idle
  task automatic run(input logic [1:0] op, input logic [7:0] d);
    wr(H_DATA, d);
    wr(H_CMD, {6'h00, op});
    idle();
  endtask : run
  // Every command opens with its own reset, so the last one is closed
  task automatic start_cmd(input logic [7:0] op, input logic [7:0] a);
    logic [7:0] s;
    run(HOP_RESET, 8'h00);
    rd(H_STAT, s);
    chk("presence", 8'h02, s & 8'h02);
    run(HOP_WRITE, OP_SKIP);
    run(HOP_WRITE, op);
    run(HOP_WRITE, a);
  endtask : start_cmd
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_speed();
    logic [7:0] s;
    rd(4'h2, s);
    chk("unmapped", 8'h00, s);
    // Standard speed gets one reset only: its byte slots take too long
    run(HOP_RESET, 8'h00);
    rd(H_STAT, s);
    chk("presence std", 8'h02, s & 8'h02);
    chk("speed std", 8'h00, {7'h00, o_overdrive});
    wr(H_CTRL, 8'h01);
    run(HOP_RESET, 8'h00);
    chk("speed od", 8'h01, {7'h00, o_overdrive});
  endtask : t_speed
  task automatic t_copy();
    start_cmd(OP_WRITE, 8'h1F);
    run(HOP_WRITE, 8'h00);
    run(HOP_WRITE, 8'h3C);
    start_cmd(OP_COPY, 8'h20);
    wr(H_CMD, {6'h00, HOP_RESET});
    for (int i = 0; i < 200 && o_copy_in_progress !== 1'h1; i++)
      @(posedge i_clk);
    chk("copy flag", 8'h01, {7'h00, o_copy_in_progress});
    repeat (COPY_N + 8) @(posedge i_clk);
    chk("copy end", 8'h00, {7'h00, o_copy_in_progress});
    idle();
    start_cmd(OP_WRITE, 8'h20);
    run(HOP_WRITE, 8'hC3);
    start_cmd(OP_RECALL, 8'h20);
  endtask : t_copy
  task automatic t_lock();
    logic [7:0] d;
    start_cmd(OP_WRITE, CTRL_ADDR);
    run(HOP_WRITE, 8'h40);
    start_cmd(OP_LOCK, 8'h20);
    start_cmd(OP_WRITE, 8'h20);
    run(HOP_WRITE, 8'hAA);
    start_cmd(OP_READ, CTRL_ADDR);
    run(HOP_READ, 8'h00);
    rd(H_DATA, d);
    chk("lock status", 8'h01, d & 8'hC3);
    run(HOP_READ, 8'h00);
    rd(H_DATA, d);
    chk("block data", 8'h3C, d);
  endtask : t_lock
  task automatic close_out();
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    #(250000 * 25);
    n_errors++;
    close_out();
  end
  initial begin
    n_errors  = 0;
    compares  = 0;
    i_sys_rst = 1'h1;
    i_addr    = 4'h0;
    i_wdata   = 8'h00;
    i_wr      = 1'h0;
    i_rd      = 1'h0;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    t_speed();
    t_copy();
    t_lock();
    close_out();
  end
endmodule : single_wire_memory_function_slave_tb
